/* logic/ebs_defs.vh */
// Constants for the external bank switch control block
`ifndef EBS_DEFS_VH
`define EBS_DEFS_VH
`define EBS_CTRL_ADDR      16'h0029
`define EBS_CTRL_RESET     16'hf000
`define EBS_CTRL_WMASK     16'hf01e
`define EBS_BIT_BACK_TO_BACK_BANK_MODE     15
`define EBS_BIT_DIV_HI     14
`define EBS_BIT_DIV_LO     13
`define EBS_BIT_ACKOFF     12
`define EBS_BIT_LIRST_N    4
`define EBS_BIT_LICLK_HALF 3
`define EBS_BIT_HOST_KEEP  2
`define EBS_BIT_DATA_KEEP  1
`define EBS_ADDR_W         18
`define EBS_BANK_BIT       15
`endif

/* logic/ebs_clk_div.v */
// Programmable clock divider, divide by code plus one, except code 0 which gives clk/2
`timescale 1ns/100ps
`default_nettype none
module ebs_clk_div #(
	parameter CW = 2
) (
	// Clock and reset
	input  wire          clk_sys,
	input  wire          nrst,
	// Divide code, ratio is code plus one, except code 0 which gives 2
	input  wire [CW-1:0] div_code,
	// Divided clock level and end-of-period pulse
	output reg           clk_out_r,
	output reg           tick_r
);
	reg [CW-1:0] cnt_r;
	wire         last;
	assign last = (cnt_r >= div_code);
	always @(posedge clk_sys) begin
		if (!nrst) begin
			cnt_r     <= {CW{1'b0}};
			clk_out_r <= 1'b0;
			tick_r    <= 1'b0;
		end else begin
			tick_r <= last;
			if (last)
				cnt_r <= {CW{1'b0}};
			else
				cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			// High for the first half of each period; code 0 toggles every cycle, giving clk/2
			if (div_code == {CW{1'b0}})
				clk_out_r <= ~clk_out_r;
			else
				clk_out_r <= (last || (cnt_r < (div_code >> 1)));
		end
	end
endmodule
`default_nettype wire

/* logic/ebs_bank_ctrl.v */
// Bank switch control register and idle cycle insertion
`timescale 1ns/100ps
`default_nettype none
`include "ebs_defs.vh"
module ebs_bank_ctrl #(
	parameter AW = `EBS_ADDR_W
) (
	// Clock and reset
	input  wire          clk_sys,
	input  wire          nrst,
	// Memory-mapped register port
	input  wire [15:0]   mmr_addr,
	input  wire [15:0]   mmr_wdata,
	input  wire          mmr_wr,
	input  wire          mmr_rd,
	output reg  [15:0]   mmr_rdata_r,
	// External access request from the core
	input  wire          acc_req,
	input  wire          acc_write,
	input  wire          acc_prog,
	input  wire [AW-1:0] acc_addr,
	output reg           acc_busy_r,
	// External memory pins
	output reg  [AW-1:0] ext_addr_r,
	output reg           memory_strobe_r,
	output reg           idle_cycle_r,
	output reg           clock_output_pin_r,
	// Interrupt acknowledge
	input  wire          ack_in,
	output reg           interrupt_acknowledge_output_r,
	// Line interface module
	output reg           line_interface_reset_n_r,
	output reg           line_interface_clk_r,
	// Bus keepers
	input  wire          wide_host_mode_pin,
	output reg           data_keeper_on_r,
	output reg           addr_keeper_on_r,
	output reg           host_keeper_on_r
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_SWAP  = 4'b0010;
	localparam ST_READ  = 4'b0100;
	localparam ST_TRAIL = 4'b1000;

	reg [15:0]   ctrl_r;
	reg [3:0]    state_r;
	reg [3:0]    state_nxt;
	reg          bank_msb_r;
	reg          last_prog_r;
	reg          last_read_r;
	reg          seen_r;
	reg [AW-1:0] addr_r;
	reg          wr_r;
	reg          prog_r;
	reg [1:0]    li_cnt_r;
	reg          swap_need;
	reg          strobe_nxt;
	reg          idle_nxt;
	reg [15:0]   rdata_nxt;
	wire         clk_div;
	wire         tick;

	wire back_to_back_bank_mode = ctrl_r[`EBS_BIT_BACK_TO_BACK_BANK_MODE];
	wire [1:0] clock_output_divider =
		ctrl_r[`EBS_BIT_DIV_HI:`EBS_BIT_DIV_LO];
	wire ack_output_suppress = ctrl_r[`EBS_BIT_ACKOFF];
	wire host_bus_keeper_enable = ctrl_r[`EBS_BIT_HOST_KEEP];
	wire data_bus_keeper_enable = ctrl_r[`EBS_BIT_DATA_KEEP];

	// Read needs a swap cycle: new bank, space change, or consecutive mode
	wire new_bank = acc_addr[`EBS_BANK_BIT] != bank_msb_r;
	wire space_swap = last_read_r && (acc_prog != last_prog_r);
	always @* begin
		swap_need = 1'b0;
		if (acc_write) begin
			// Writes never take a swap cycle
			swap_need = 1'b0;
		end else if (back_to_back_bank_mode) begin
			swap_need = 1'b1;
		end else if (!seen_r) begin
			// Last bank unknown after reset, so play safe
			swap_need = 1'b1;
		end else if (new_bank) begin
			swap_need = 1'b1;
		end else if (space_swap) begin
			swap_need = 1'b1;
		end else begin
			swap_need = 1'b0;
		end
	end

	ebs_clk_div #(
		.CW(2)
	) u_div (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.div_code  (clock_output_divider),
		.clk_out_r (clk_div),
		.tick_r    (tick)
	);

	// Register port decode
	wire reg_hit = (mmr_addr == `EBS_CTRL_ADDR);
	always @* begin
		rdata_nxt = 16'h0000;
		if (mmr_rd && reg_hit)
			rdata_nxt = ctrl_r & `EBS_CTRL_WMASK;
	end

	// Reserved bits masked on write
	always @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_r <= `EBS_CTRL_RESET;
		end else if (mmr_wr && reg_hit) begin
			ctrl_r <= mmr_wdata & `EBS_CTRL_WMASK;
		end
	end

	// Read data stands one cycle, zero otherwise
	always @(posedge clk_sys) begin
		if (!nrst)
			mmr_rdata_r <= 16'h0000;
		else
			mmr_rdata_r <= rdata_nxt;
	end

	// Sequencer leaves ST_IDLE on any clock, then advances once per divider tick, every code plus one clocks
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (acc_req)
				state_nxt = swap_need ? ST_SWAP : ST_READ;
		end
		ST_SWAP:  state_nxt = ST_READ;
		ST_READ: begin
			if (!wr_r && back_to_back_bank_mode)
				state_nxt = ST_TRAIL;
			else
				state_nxt = ST_IDLE;
		end
		ST_TRAIL: state_nxt = ST_IDLE;
		default:  state_nxt = ST_IDLE;
		endcase
	end

	// Pin levels for the state about to be entered
	always @* begin
		strobe_nxt = 1'b0;
		idle_nxt   = 1'b0;
		case (state_nxt)
		ST_SWAP:  idle_nxt   = 1'b1;
		ST_READ:  strobe_nxt = 1'b1;
		ST_TRAIL: idle_nxt   = 1'b1;
		default: begin
			strobe_nxt = 1'b0;
			idle_nxt   = 1'b0;
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			state_r         <= ST_IDLE;
			bank_msb_r      <= 1'b0;
			last_prog_r     <= 1'b0;
			last_read_r     <= 1'b0;
			seen_r          <= 1'b0;
			addr_r          <= {AW{1'b0}};
			wr_r            <= 1'b0;
			prog_r          <= 1'b0;
			ext_addr_r      <= {AW{1'b0}};
			memory_strobe_r <= 1'b0;
			idle_cycle_r    <= 1'b0;
			acc_busy_r      <= 1'b0;
		end else if (state_r == ST_IDLE || tick) begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE && acc_req) begin
				addr_r     <= acc_addr;
				wr_r       <= acc_write;
				prog_r     <= acc_prog;
				// Address moves as the request is taken, with the swap cycle or with the strobe
				ext_addr_r <= acc_addr;
				acc_busy_r <= 1'b1;
				// Tracked on reads and writes alike
				bank_msb_r  <= acc_addr[`EBS_BANK_BIT];
				last_prog_r <= acc_prog;
				last_read_r <= !acc_write;
				seen_r      <= 1'b1;
			end
			memory_strobe_r <= strobe_nxt;
			idle_cycle_r    <= idle_nxt;
			if (state_nxt == ST_IDLE)
				acc_busy_r <= 1'b0;
		end
	end

	// Line interface clock source: bit 0 is clk/2, bit 1 is clk/4
	always @(posedge clk_sys) begin
		if (!nrst) begin
			li_cnt_r <= 2'b00;
		end else begin
			li_cnt_r <= li_cnt_r + 2'b01;
		end
	end

	// A flop output cannot run at clk, so both rates are halved
	always @(posedge clk_sys) begin
		if (!nrst) begin
			line_interface_clk_r <= 1'b0;
		end else if (ctrl_r[`EBS_BIT_LICLK_HALF]) begin
			line_interface_clk_r <= li_cnt_r[1];
		end else begin
			line_interface_clk_r <= li_cnt_r[0];
		end
	end

	// Line interface held in reset while bit 4 is low
	always @(posedge clk_sys) begin
		if (!nrst) begin
			line_interface_reset_n_r <= 1'b0;
		end else begin
			line_interface_reset_n_r <=
				ctrl_r[`EBS_BIT_LIRST_N];
		end
	end

	// Ack passes only while suppression is off
	always @(posedge clk_sys) begin
		if (!nrst) begin
			interrupt_acknowledge_output_r <= 1'b0;
		end else if (ack_output_suppress) begin
			interrupt_acknowledge_output_r <= 1'b0;
		end else begin
			interrupt_acknowledge_output_r <= ack_in;
		end
	end

	// Divider output retimed so the pin comes from a flop
	always @(posedge clk_sys) begin
		if (!nrst) begin
			clock_output_pin_r <= 1'b0;
		end else begin
			clock_output_pin_r <= clk_div;
		end
	end

	// Data bus keeper follows its own bit only
	always @(posedge clk_sys) begin
		if (!nrst) begin
			data_keeper_on_r <= 1'b0;
		end else begin
			data_keeper_on_r <= data_bus_keeper_enable;
		end
	end

	// Address keeper needs wide host mode and both bits
	always @(posedge clk_sys) begin
		if (!nrst) begin
			addr_keeper_on_r <= 1'b0;
		end else if (wide_host_mode_pin) begin
			addr_keeper_on_r <= data_bus_keeper_enable &&
				host_bus_keeper_enable;
		end else begin
			addr_keeper_on_r <= 1'b0;
		end
	end

	// Wide host mode forces the host keeper on
	always @(posedge clk_sys) begin
		if (!nrst) begin
			host_keeper_on_r <= 1'b0;
		end else if (wide_host_mode_pin) begin
			host_keeper_on_r <= 1'b1;
		end else begin
			host_keeper_on_r <= host_bus_keeper_enable;
		end
	end
endmodule
`default_nettype wire

/* verif/ebs_monitor.sv */
// Checker for the bank switch control block
`timescale 1ns/100ps
`default_nettype none
module ebs_monitor (
	// Watched ports
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic [15:0] mmr_addr,
	input wire logic        mmr_rd,
	input wire logic [15:0] mmr_rdata_r,
	input wire logic        acc_req,
	input wire logic        acc_busy_r,
	input wire logic        memory_strobe_r,
	input wire logic        idle_cycle_r,
	input wire logic        ack_in,
	input wire logic        interrupt_acknowledge_output_r,
	input wire logic        wide_host_mode_pin,
	input wire logic        data_keeper_on_r,
	input wire logic        addr_keeper_on_r,
	input wire logic        host_keeper_on_r
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!nrst);
AST_UNMAPPED: assert property (mmr_rd && mmr_addr != 16'h0029
	|=> mmr_rdata_r == 16'h0000) else $error("bad read");
AST_RSVD: assert property (mmr_rdata_r[11:5] == 0
	&& !mmr_rdata_r[0]) else $error("rsvd set");
AST_TAKE: assert property (acc_req && !acc_busy_r
	|=> acc_busy_r) else $error("not taken");
AST_STB_DUE: assert property ($rose(acc_busy_r)
	|-> ##[0:9] memory_strobe_r) else $error("no strobe");
AST_EXCL: assert property (!(memory_strobe_r && idle_cycle_r))
	else $error("strobe in idle");
AST_INSEQ: assert property (memory_strobe_r || idle_cycle_r
	|-> acc_busy_r) else $error("stray cycle");
AST_ACK: assert property (interrupt_acknowledge_output_r
	|-> $past(ack_in)) else $error("ack");
AST_HKEEP: assert property ($past(wide_host_mode_pin && nrst)
	|-> host_keeper_on_r) else $error("host keep");
AST_AKEEP: assert property (addr_keeper_on_r
	|-> $past(wide_host_mode_pin) && data_keeper_on_r) else $error("akeep");
cover property ($rose(idle_cycle_r));
cover property ($rose(memory_strobe_r) && $past(!idle_cycle_r));
cover property (addr_keeper_on_r);
endmodule
`default_nettype wire

/* verif/ebs_mem_model.sv */
// External memory model that counts rising edges of the strobe, one per access
`timescale 1ns/100ps
`default_nettype none
module ebs_mem_model (
	// Memory side
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        memory_strobe_r,
	output var  logic [15:0] hit_cnt
);
	logic prev;
	always @(posedge clk_sys) begin
		prev <= memory_strobe_r;
		if (!nrst)
			hit_cnt <= 16'h0000;
		else if (memory_strobe_r && !prev)
			hit_cnt <= hit_cnt + 16'h0001;
	end
endmodule
`default_nettype wire

/* verif/external_bank_switch_control_tb.sv */
// Testbench for the bank switch control block
`timescale 1ns/100ps
`default_nettype none
module external_bank_switch_control_tb;
	logic clk_sys = 0, nrst = 0, mmr_wr = 0, mmr_rd = 0, acc_req = 0;
	logic acc_write = 0, acc_prog = 0, ack_in = 0, wide_host_mode_pin = 0;
	logic [15:0] mmr_addr = 0, mmr_wdata = 0, mmr_rdata_r, hit_cnt, cr, w;
	logic [17:0] acc_addr = 0, ext_addr_r;
	logic acc_busy_r, memory_strobe_r, idle_cycle_r, clock_output_pin_r;
	logic interrupt_acknowledge_output_r, line_interface_reset_n_r, lp, lr;
	logic line_interface_clk_r, data_keeper_on_r, addr_keeper_on_r;
	logic host_keeper_on_r;
	logic [31:0] r;
	int n_mismatch = 0, checks = 0, lb = -1, nacc = 0, k;
	always #25 clk_sys = ~clk_sys;
	ebs_bank_ctrl u_dut (.*);
	ebs_mem_model u_mem (.*);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic reg_io(input logic wr, input logic [15:0] a, d);
		@(posedge clk_sys);
		mmr_addr <= a;
		mmr_wdata <= d;
		mmr_wr <= wr;
		mmr_rd <= !wr;
		@(posedge clk_sys);
		mmr_wr <= 1'b0;
		mmr_rd <= 1'b0;
		#1;
		if (!wr) cmp(mmr_rdata_r, d);
	endtask
	task automatic clk_chk(input logic sel, input int e);
		int i, n;
		logic pv, cv;
		n = 0;
		pv = sel ? line_interface_clk_r : clock_output_pin_r;
		for (i = 0; i < 24; i++) begin
			@(posedge clk_sys);
			#1;
			cv = sel ? line_interface_clk_r : clock_output_pin_r;
			if (cv === 1'b1 && pv === 1'b0) n++;
			pv = cv;
		end
		cmp(n, e);
	endtask
	task automatic acc(input logic wt, p, input logic [17:0] a);
		logic sw, st, tr, e;
		logic [17:0] ad;
		int i;
		sw = 0;
		st = 0;
		tr = 0;
		ad = 0;
		e = !wt && (cr[15] || lb < 0 || lb != a[15] || (lr && lp != p));
		@(posedge clk_sys);
		acc_req <= 1'b1;
		acc_write <= wt;
		acc_prog <= p;
		acc_addr <= a;
		@(posedge clk_sys);
		acc_req <= 1'b0;
		for (i = 0; i < 40; i++) begin
			#1;
			if (acc_busy_r !== 1'b1) break;
			if (memory_strobe_r === 1'b1) begin
				st = 1;
				ad = ext_addr_r;
			end else if (idle_cycle_r === 1'b1) begin
				if (st) tr = 1;
				else sw = 1;
			end
			@(posedge clk_sys);
		end
		if (i == 40) begin
			cmp(0, 1);
			wrap_up;
		end
		cmp({st, sw}, {1'b1, e});
		cmp(ad, a);
		cmp(tr, !wt && cr[15]);
		lb = a[15];
		lp = p;
		lr = !wt;
		nacc++;
	endtask
	initial begin
		void'($urandom(97323));
		cr = 16'hf000;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		reg_io(0, 16'h0029, 16'hf000);
		cmp(line_interface_reset_n_r, 0);
		reg_io(0, 16'h0028, 16'h0000);
		for (k = 0; k < 12; k++) begin
			w = $urandom;
			@(posedge clk_sys);
			wide_host_mode_pin <= w[0];
			ack_in <= w[5];
			reg_io(1, 16'h0029, w);
			cr = w & 16'hf01e;
			reg_io(0, 16'h0029, cr);
			cmp(line_interface_reset_n_r, cr[4]);
			cmp(data_keeper_on_r, cr[1]);
			cmp(host_keeper_on_r, cr[2] | w[0]);
			cmp(addr_keeper_on_r, cr[1] & cr[2] & w[0]);
			cmp(interrupt_acknowledge_output_r, w[5] & !cr[12]);
			if (cr[14:13] != 2'b00) clk_chk(0, 24 / (cr[14:13] + 1));
			clk_chk(1, cr[3] ? 6 : 12);
			repeat (6) begin
				r = $urandom;
				acc(r[0], r[1], r[31:14]);
			end
		end
		cmp(hit_cnt, nacc);
		wrap_up;
	end
endmodule
bind ebs_bank_ctrl ebs_monitor u_mon (.*);
`default_nettype wire
